// ==== pkg/smbtpc_pkg.sv ====
/*
 * Constants shared by the two-wire bus timing and pin control block:
 * special-function addresses, register field positions, reset values,
 * timing counts and the START window decode function.
 * Assumes a single system clock domain for every user of the package.
 */
package smbtpc_pkg;

    // ------------------------------------------------------------------
    // Register addresses.
    // ------------------------------------------------------------------
    localparam logic [7:0] SMBTPC_TC_ADDR   = 8'hC7; // Timing/pin control.
    localparam logic [7:0] SMBTPC_CF_ADDR   = 8'hC1; // Second bus config.
    localparam logic [7:0] SMBTPC_CF_PAGE   = 8'h0F; // Page of config reg.
    localparam logic [7:0] SMBTPC_TC_RESET  = 8'h00; // Timing reset value.
    localparam logic [7:0] SMBTPC_CF_RESET  = 8'h00; // Config reset value.

    // ------------------------------------------------------------------
    // Timing/pin control fields.
    // ------------------------------------------------------------------
    localparam int SMBTPC_TC_SWAP1  = 7; // Second controller pin swap.
    localparam int SMBTPC_TC_SWAP0  = 6; // First controller pin swap.
    localparam int SMBTPC_TC_WIN1   = 2; // Second START window, LSB.
    localparam int SMBTPC_TC_WIN0   = 0; // First START window, LSB.

    // ------------------------------------------------------------------
    // Second bus configuration fields.
    // ------------------------------------------------------------------
    localparam int SMBTPC_CF_EN     = 7; // Interface enable.
    localparam int SMBTPC_CF_INH    = 6; // Slave inhibit.
    localparam int SMBTPC_CF_BUSY   = 5; // Busy flag, read only.
    localparam int SMBTPC_CF_EXTH   = 4; // Setup/hold extension.
    localparam int SMBTPC_CF_TOE    = 3; // SCL low timeout enable.
    localparam int SMBTPC_CF_FTE    = 2; // Free timeout enable.
    localparam int SMBTPC_CF_CS     = 0; // Bit-rate source, LSB.

    // ------------------------------------------------------------------
    // Timing counts.
    // ------------------------------------------------------------------
    localparam logic [3:0] SMBTPC_FREE_PERIODS = 4'hA; // Idle periods.
    localparam logic [3:0] SMBTPC_WIN_MIN_00   = 4'h0; // 0-1 clocks.
    localparam logic [3:0] SMBTPC_WIN_MIN_01   = 4'h2; // 2-3 clocks.
    localparam logic [3:0] SMBTPC_WIN_MIN_10   = 4'h4; // 4-5 clocks.
    localparam logic [3:0] SMBTPC_WIN_MIN_11   = 4'h8; // 8-9 clocks.

    // Least number of clocks data must stay low with clock high.
    function automatic logic [3:0] smbtpc_win_min(input logic [1:0] sel);
        case (sel)
            2'h0:    smbtpc_win_min = SMBTPC_WIN_MIN_00;
            2'h1:    smbtpc_win_min = SMBTPC_WIN_MIN_01;
            2'h2:    smbtpc_win_min = SMBTPC_WIN_MIN_10;
            default: smbtpc_win_min = SMBTPC_WIN_MIN_11;
        endcase
    endfunction

endpackage

// ==== verilog/smbtpc_start_det.sv ====
/*
 * START and STOP detector for one two-wire bus controller, with a
 * programmable window between data falling and clock falling.
 * Assumes sda and scl are already synchronised to ref_clk.
 */
`timescale 1ns/1ps
module smbtpc_start_det
    import smbtpc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic       enable,
    input  wire logic [1:0] window_sel,
    input  wire logic       sda,
    input  wire logic       scl,
    output logic            start_pulse,
    output logic            stop_pulse
);

    // ------------------------------------------------------------------
    // State and storage.
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SMBTPC_IDLE  = 2'b01,   // Waiting for data to fall.
        SMBTPC_ARMED = 2'b10    // Data fell with clock high, counting.
    } smbtpc_det_t;

    smbtpc_det_t state_reg;     // Detector state.
    smbtpc_det_t state_next;    // Next detector state.
    logic [3:0]  cnt_reg;       // Clocks since data fell.
    logic [3:0]  cnt_next;      // Next count.
    logic        sda_prev_reg;  // Data one clock ago.
    logic        start_next;    // Next START pulse.
    logic        stop_next;     // Next STOP pulse.
    wire  [3:0]  win_min = smbtpc_win_min(window_sel);
    wire         sda_fall = sda_prev_reg & ~sda & scl;
    wire         sda_rise = ~sda_prev_reg & sda & scl;

    // ------------------------------------------------------------------
    // Next-state logic.
    // ------------------------------------------------------------------
    // The window counts from the data fall; a clock fall or data
    // rise before the count reaches the minimum discards the START.
    always_comb
    begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        start_next = 1'b0;
        stop_next  = enable & sda_rise;
        case (state_reg)
            SMBTPC_IDLE:
            begin
                if (enable && sda_fall)
                begin
                    if (win_min == 4'h0)
                    begin
                        start_next = 1'b1; // RULE_15
                    end
                    else
                    begin
                        state_next = SMBTPC_ARMED;
                        cnt_next   = 4'h1;
                    end
                end
            end
            SMBTPC_ARMED:
            begin
                if (!enable || !scl || sda)
                begin
                    state_next = SMBTPC_IDLE; // RULE_15
                end
                else if (cnt_reg >= win_min)
                begin
                    start_next = 1'b1; // RULE_10 RULE_11
                    state_next = SMBTPC_IDLE;
                end
                else
                begin
                    cnt_next = cnt_reg + 4'h1;
                end
            end
            default:
            begin
                state_next = SMBTPC_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Registers.
    // ------------------------------------------------------------------
    // The previous data level resets high, the idle level of the bus.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg    <= SMBTPC_IDLE;
            cnt_reg      <= 4'h0;
            sda_prev_reg <= 1'b1;
            start_pulse  <= 1'b0;
            stop_pulse   <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            sda_prev_reg <= sda;
            start_pulse  <= start_next;
            stop_pulse   <= stop_next;
        end
    end

endmodule // smbtpc_start_det

// ==== verilog/smbtpc_top.sv ====
/*
 * Timing and pin configuration logic for two two-wire bus controllers:
 * registers, bit-rate source selection, timeouts, pin swapping and
 * START/STOP detection.
 * Assumes the controller cores, timers and crossbar pads sit outside;
 * pad levels are asynchronous, everything else is on ref_clk.
 */
`timescale 1ns/1ps
// Function
// RULE_01 - timeout on: reload timer while clock high
// RULE_02 - split timer: only high byte held
// RULE_03 - software sets timer for 25 ms
// RULE_04 - bus free after ten idle source periods
// RULE_05 - two bits pick bit-rate source
// RULE_06 - extension bit selects longer setup/hold
// RULE_07 - second swap bit orders its pins
// RULE_08 - first swap bit orders its pins
// RULE_09 - software swaps pins for EEPROM access
// RULE_10 - second controller START window by field
// RULE_11 - first controller START window independent
// RULE_12 - timing register at 0xC7, all pages
// RULE_13 - enable bit makes interface monitor pins
// RULE_14 - busy set in transfer, cleared stop/free
// RULE_15 - START counts clocks from data fall
module smbtpc_top
    import smbtpc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       nrst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic [7:0] sfr_page,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic [3:0] pad_in,
    output logic      [3:0] pad_out,
    output logic      [3:0] pad_oe_n,
    input  wire logic       c0_enable,
    input  wire logic       c0_sda_drive_low,
    input  wire logic       c0_scl_drive_low,
    input  wire logic       c1_sda_drive_low,
    input  wire logic       c1_scl_drive_low,
    output logic            c0_sda,
    output logic            c0_scl,
    output logic            c1_sda,
    output logic            c1_scl,
    output logic            c0_start,
    output logic            c0_stop,
    output logic            c1_start,
    output logic            c1_stop,
    input  wire logic       t0_ovf,
    input  wire logic       t5_ovf,
    input  wire logic       t2h_ovf,
    input  wire logic       t2l_ovf,
    input  wire logic       t4_split,
    output logic            c1_bitrate_tick,
    output logic            c1_bus_free,
    output logic            c1_busy,
    output logic            c1_enable,
    output logic            c1_inhibit,
    output logic            c1_setup_hold_extend,
    output logic            t4_reload_low,
    output logic            t4_reload_high
);

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    logic [7:0] tc_reg;         // Timing and pin control register.
    logic [7:0] cf_reg;         // Second bus config, busy bit unused.
    logic       busy_reg;       // Transfer in progress, second bus.
    logic       busy_next;      // Next busy value.
    logic [3:0] free_cnt_reg;   // Source periods with both lines high.
    logic [3:0] free_cnt_next;  // Next idle count.
    logic [3:0] pad_meta_reg;   // First synchroniser stage.
    logic [3:0] pad_sync_reg;   // Second synchroniser stage.
    logic       det0_start;     // First controller START pulse.
    logic       det0_stop;      // First controller STOP pulse.
    logic       det1_start;     // Second controller START pulse.
    logic       det1_stop;      // Second controller STOP pulse.

    // Field views of the registers.
    wire        swap0   = tc_reg[SMBTPC_TC_SWAP0];
    wire        swap1   = tc_reg[SMBTPC_TC_SWAP1];
    wire  [1:0] win0    = tc_reg[SMBTPC_TC_WIN0 +: 2];
    wire  [1:0] win1    = tc_reg[SMBTPC_TC_WIN1 +: 2];
    wire        en1     = cf_reg[SMBTPC_CF_EN];
    wire        toe1    = cf_reg[SMBTPC_CF_TOE];
    wire        fte1    = cf_reg[SMBTPC_CF_FTE];
    wire  [1:0] cs1     = cf_reg[SMBTPC_CF_CS +: 2];

    // ------------------------------------------------------------------
    // Register decode.
    // ------------------------------------------------------------------
    // The timing register answers on every page; the config register
    // only on its own page.
    wire tc_hit = (sfr_addr == SMBTPC_TC_ADDR); // RULE_12
    wire cf_hit = (sfr_addr == SMBTPC_CF_ADDR)
                & (sfr_page == SMBTPC_CF_PAGE);
    wire [7:0] cf_view = {cf_reg[7:6], busy_reg, cf_reg[4:0]};
    wire [7:0] rdata_next = tc_hit ? tc_reg : (cf_hit ? cf_view : 8'h00);

    // ------------------------------------------------------------------
    // Pin mapping.
    // ------------------------------------------------------------------
    // Picks data or clock for the lower-numbered pad of a pair.
    function automatic logic smbtpc_lo_pick(input logic swap,
                                            input logic sda_v,
                                            input logic scl_v);
        smbtpc_lo_pick = swap ? scl_v : sda_v;
    endfunction

    // Pads 0/1 belong to the first controller, pads 2/3 to the second.
    wire [3:0] drive_low = {
        smbtpc_lo_pick(swap1, c1_scl_drive_low, c1_sda_drive_low),
        smbtpc_lo_pick(swap1, c1_sda_drive_low, c1_scl_drive_low), // RULE_07
        smbtpc_lo_pick(swap0, c0_scl_drive_low, c0_sda_drive_low),
        smbtpc_lo_pick(swap0, c0_sda_drive_low, c0_scl_drive_low)  // RULE_08
    };
    wire sda0_in = smbtpc_lo_pick(swap0, pad_sync_reg[0], pad_sync_reg[1]);
    wire scl0_in = smbtpc_lo_pick(swap0, pad_sync_reg[1], pad_sync_reg[0]);
    wire sda1_in = smbtpc_lo_pick(swap1, pad_sync_reg[2], pad_sync_reg[3]);
    wire scl1_in = smbtpc_lo_pick(swap1, pad_sync_reg[3], pad_sync_reg[2]);

    // ------------------------------------------------------------------
    // Bit-rate source, free timeout and busy.
    // ------------------------------------------------------------------
    wire src_tick = (cs1 == 2'h0) ? t0_ovf :
                    (cs1 == 2'h1) ? t5_ovf :
                    (cs1 == 2'h2) ? t2h_ovf : t2l_ovf; // RULE_05
    wire bus_idle = en1 & scl1_in & sda1_in;
    // More than ten periods: the eleventh tick of an idle stretch.
    wire free_hit = fte1 & bus_idle & src_tick
                  & (free_cnt_reg == SMBTPC_FREE_PERIODS); // RULE_04
    assign free_cnt_next = !bus_idle ? 4'h0 :
                           (src_tick && free_cnt_reg != SMBTPC_FREE_PERIODS)
                           ? free_cnt_reg + 4'h1 : free_cnt_reg;
    // A START in the same cycle as a STOP or free clear wins; only disabling the interface overrides it.
    assign busy_next = !en1 ? 1'b0 :
                       det1_start ? 1'b1 :
                       (det1_stop | free_hit) ? 1'b0 : busy_reg; // RULE_14

    // ------------------------------------------------------------------
    // START detectors, one per controller.
    // ------------------------------------------------------------------
    smbtpc_start_det u_det0
    (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .enable      (c0_enable),
        .window_sel  (win0),             // RULE_11
        .sda         (sda0_in),
        .scl         (scl0_in),
        .start_pulse (det0_start),
        .stop_pulse  (det0_stop)
    );

    smbtpc_start_det u_det1
    (
        .ref_clk     (ref_clk),
        .nrst        (nrst),
        .enable      (en1),              // RULE_13
        .window_sel  (win1),             // RULE_10
        .sda         (sda1_in),
        .scl         (scl1_in),
        .start_pulse (det1_start),
        .stop_pulse  (det1_stop)
    );

    // ------------------------------------------------------------------
    // Register writes.
    // ------------------------------------------------------------------
    // Reserved timing bits 5:4 are kept at zero whatever is written.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            tc_reg <= SMBTPC_TC_RESET; // RULE_12
            cf_reg <= SMBTPC_CF_RESET;
        end
        else
        begin
            if (sfr_wr && tc_hit)
            begin
                tc_reg <= sfr_wdata & 8'hCF;
            end
            if (sfr_wr && cf_hit)
            begin
                cf_reg <= sfr_wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // Pad synchroniser.
    // ------------------------------------------------------------------
    // Pads idle high, so both stages reset high to avoid a false edge.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pad_meta_reg <= 4'hF;
            pad_sync_reg <= 4'hF;
        end
        else
        begin
            pad_meta_reg <= pad_in;
            pad_sync_reg <= pad_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // State and output registers.
    // ------------------------------------------------------------------
    // All outputs are registered, so they lag their causes by one clock.
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            busy_reg             <= 1'b0;
            free_cnt_reg         <= 4'h0;
            sfr_rdata            <= 8'h00;
            pad_out              <= 4'h0;
            pad_oe_n             <= 4'hF;
            c0_sda               <= 1'b1;
            c0_scl               <= 1'b1;
            c1_sda               <= 1'b1;
            c1_scl               <= 1'b1;
            c0_start             <= 1'b0;
            c0_stop              <= 1'b0;
            c1_start             <= 1'b0;
            c1_stop              <= 1'b0;
            c1_bitrate_tick      <= 1'b0;
            c1_bus_free          <= 1'b0;
            c1_busy              <= 1'b0;
            c1_enable            <= 1'b0;
            c1_inhibit           <= 1'b0;
            c1_setup_hold_extend <= 1'b0;
            t4_reload_low        <= 1'b0;
            t4_reload_high       <= 1'b0;
        end
        else
        begin
            busy_reg             <= busy_next;
            free_cnt_reg         <= free_cnt_next;
            sfr_rdata            <= rdata_next;
            pad_out              <= 4'h0;
            pad_oe_n             <= ~drive_low; // RULE_07 RULE_08
            c0_sda               <= sda0_in;
            c0_scl               <= scl0_in;
            c1_sda               <= sda1_in;
            c1_scl               <= scl1_in;
            c0_start             <= det0_start;
            c0_stop              <= det0_stop;
            c1_start             <= det1_start;
            c1_stop              <= det1_stop;
            c1_bitrate_tick      <= en1 & src_tick; // RULE_05
            c1_bus_free          <= free_hit;       // RULE_04
            c1_busy              <= busy_next;
            c1_enable            <= en1;
            c1_inhibit           <= cf_reg[SMBTPC_CF_INH];
            c1_setup_hold_extend <= cf_reg[SMBTPC_CF_EXTH]; // RULE_06
            t4_reload_high       <= en1 & toe1 & scl1_in;   // RULE_01
            t4_reload_low        <= en1 & toe1 & scl1_in
                                  & ~t4_split;              // RULE_02
        end
    end

endmodule // smbtpc_top

// ==== tb/smbtpc_top_props.sv ====
/* Port assertions for the bus timing and pin control top.
   Assumes one ref_clk domain and the active-low reset nrst. */
`timescale 1ns/1ps
module smbtpc_top_props
    import smbtpc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic c1_sda,
    input wire logic c1_scl,
    input wire logic c1_start,
    input wire logic c1_stop,
    input wire logic c1_busy,
    input wire logic c1_bus_free,
    input wire logic c1_bitrate_tick,
    input wire logic t0_ovf,
    input wire logic t5_ovf,
    input wire logic t2h_ovf,
    input wire logic t2l_ovf,
    input wire logic t4_split,
    input wire logic t4_reload_low,
    input wire logic t4_reload_high
);
    // ----------------------------------------------------------------
    // Every check samples on ref_clk and sleeps through reset.
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    AST_SPLIT_LOW: assert property
        (t4_reload_low |-> t4_reload_high)
        else $error("Low byte held in reload without the high byte.");
    AST_SPLIT_HOLD: assert property
        ($past(t4_split) |-> !t4_reload_low)
        else $error("Low byte held in reload in split mode.");
    AST_RELOAD_SCL: assert property
        (t4_reload_high |-> c1_scl || $past(c1_scl))
        else $error("Timer held in reload while the clock is low.");
    AST_TICK_SRC: assert property
        (c1_bitrate_tick |-> $past(t0_ovf|t5_ovf|t2h_ovf|t2l_ovf))
        else $error("Bit-rate tick without any overflow.");
    AST_START_LINES: assert property
        (c1_start |-> $past(c1_scl) && !$past(c1_sda))
        else $error("START seen without data low under a high clock.");
    AST_STOP_LINES: assert property
        (c1_stop |-> $past(c1_sda) && $past(c1_scl))
        else $error("STOP seen without both lines high.");
    AST_BUSY_SET: assert property
        (c1_start |-> ##[0:1] c1_busy)
        else $error("Busy not set after a START.");
    AST_FREE_LINES: assert property
        (c1_bus_free |-> $past(c1_sda) && $past(c1_scl) ##1 !c1_busy)
        else $error("Bus free without idle lines, or busy kept.");
endmodule // smbtpc_top_props

bind smbtpc_top smbtpc_top_props u_props (
    .ref_clk, .nrst, .c1_sda, .c1_scl, .c1_start, .c1_stop, .c1_busy,
    .c1_bus_free, .c1_bitrate_tick, .t0_ovf, .t5_ovf, .t2h_ovf,
    .t2l_ovf, .t4_split, .t4_reload_low, .t4_reload_high
);

// ==== tb/smbtpc_bus_model.sv ====
/* Far-side devices sharing the four crossbar pads.
   Assumes open-drain pads with pull-ups; the bench picks the pulls. */
`timescale 1ns/1ps
module smbtpc_bus_model
(
    input  wire logic [3:0] pad_oe_n,
    input  wire logic [3:0] far_low,
    output logic      [3:0] pad_in
);
    // A pad is low when either party pulls it; a released pad goes
    // high by its pull-up, so no stale level is ever shown.
    assign pad_in = ~(far_low | ~pad_oe_n);
endmodule // smbtpc_bus_model

// ==== tb/smbtpc_top_tb_top.sv ====
/* Self-checking bench for the bus timing and pin control block.
   Assumes the far-side pad model; inputs change at falling edges. */
`timescale 1ns/1ps
module smbtpc_top_tb_top
    import smbtpc_pkg::*;
;
    // ----------------------------------------------------------------
    // Stimulus, observed outputs and counters.
    // ----------------------------------------------------------------
    logic       ref_clk, nrst, sfr_wr, c0_enable, t4_split;
    logic [7:0] sfr_addr, sfr_page, sfr_wdata, sfr_rdata;
    logic [3:0] dl, ovf, far_low, pad_in, pad_oe_n; // Pulls and ticks.
    logic       c1_sda, c0_start, c1_start, c1_stop, c1_busy, c1_bus_free;
    logic       c1_bitrate_tick, c1_setup_hold_extend, c1_enable, c1_inhibit;
    logic       t4_reload_low, t4_reload_high, c0_sda, c0_scl, c1_scl, c0_stop;
    logic [3:0] pad_out;                            // Open-drain, never high.
    int         n_errors, comparisons, ns[2], np, nf, nt;
    int         wmin[4] = '{0, 2, 4, 8};   // Least START hold, clocks.

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // Event counters; tests compare before and after a step.
    always @(posedge ref_clk)
    begin
        ns[0] += int'(c0_start === 1'b1);
        ns[1] += int'(c1_start === 1'b1);
        np += int'((c0_stop | c1_stop) === 1'b1);
        nf += int'(c1_bus_free === 1'b1);
        nt += int'(c1_bitrate_tick === 1'b1);
    end

    smbtpc_top dut (
        .ref_clk, .nrst, .sfr_addr, .sfr_page, .sfr_wr, .sfr_wdata,
        .sfr_rdata, .pad_in, .pad_out, .pad_oe_n, .c0_enable,
        .c0_sda_drive_low(dl[0]), .c0_scl_drive_low(dl[1]),
        .c1_sda_drive_low(dl[2]), .c1_scl_drive_low(dl[3]),
        .c0_sda, .c0_scl, .c1_sda, .c1_scl, .c0_start, .c0_stop,
        .c1_start, .c1_stop, .t0_ovf(ovf[0]), .t5_ovf(ovf[1]),
        .t2h_ovf(ovf[2]), .t2l_ovf(ovf[3]), .t4_split, .c1_bitrate_tick,
        .c1_bus_free, .c1_busy, .c1_enable, .c1_inhibit,
        .c1_setup_hold_extend, .t4_reload_low, .t4_reload_high
    );
    smbtpc_bus_model far (.pad_oe_n, .far_low, .pad_in);

    // ----------------------------------------------------------------
    // Access and comparison tasks.
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic [7:0] a, pg, d);
        @(negedge ref_clk);
        {sfr_addr, sfr_page, sfr_wdata, sfr_wr} = {a, pg, d, 1'b1};
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, pg, e);
        @(negedge ref_clk);
        {sfr_addr, sfr_page} = {a, pg};
        @(negedge ref_clk);
        chk(sfr_rdata, e);
    endtask
    // Data falls under a high clock, the clock falls h cycles later,
    // one bit clock runs at 80 ns, then the clock is released and a STOP closes the frame.
    task automatic frame(input int c, input int h, input logic e);
        int n, p;
        {n, p} = {ns[c], np};
        cyc(1);
        far_low[2 * c] = 1'b1;
        cyc(h);
        far_low[2 * c + 1] = 1'b1;
        repeat (2) #40 far_low[2 * c + 1] = ~far_low[2 * c + 1];
        #80 chk(8'(ns[c] - n), 8'(e));
        if (c == 1) chk({7'h00, c1_busy}, 8'(e));
        #40 far_low[2 * c + 1] = 1'b0;
        cyc(4);
        far_low[2 * c] = 1'b0;      // Data rises under a high clock.
        cyc(8);
        chk(8'(np - p) + {7'h00, c1_busy}, 8'h01);
    endtask
    task automatic final_report();
        if (n_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // The whole run needs under a thousand cycles; this guards a hang.
    initial
    begin
        #200000;
        n_errors++;
        final_report();
    end

    initial
    begin
        int s, i, k;
        logic [7:0] e;
        {nrst, sfr_wr, c0_enable, t4_split} = 4'h0;
        {sfr_addr, sfr_page, sfr_wdata, dl, ovf, far_low} = 36'h0;
        cyc(4);
        nrst = 1'b1;
        c0_enable = 1'b1;
        rd(SMBTPC_TC_ADDR, 8'h05, SMBTPC_TC_RESET);
        rd(SMBTPC_CF_ADDR, SMBTPC_CF_PAGE, SMBTPC_CF_RESET);
        wr(SMBTPC_TC_ADDR, 8'h3A, 8'hFF);
        rd(SMBTPC_TC_ADDR, 8'h00, 8'hCF);
        wr(SMBTPC_CF_ADDR, SMBTPC_CF_PAGE, 8'h7F);
        wr(SMBTPC_CF_ADDR, 8'h00, 8'h00);
        rd(SMBTPC_CF_ADDR, SMBTPC_CF_PAGE, 8'h5F);
        chk({7'h00, c1_setup_hold_extend}, 8'h01);
        chk({6'h00, c1_enable, c1_inhibit}, 8'h01);
        rd(8'h55, 8'h00, 8'h00);
        // Cores pull first data and second clock; far side pulls pad 2.
        {dl, far_low} = 8'h94;
        for (s = 0; s < 4; s++)
        begin
            wr(SMBTPC_TC_ADDR, 8'(s), 8'(s << 6));
            cyc(5);
            e = 8'h0F;
            e[s % 2] = 1'b0;
            e[(s / 2) ? 2 : 3] = 1'b0;
            chk({pad_out, pad_oe_n}, e);
            chk({6'h00, c1_sda, c1_scl}, 8'(s & 2));
            chk({6'h00, c0_sda, c0_scl}, 8'h01);
        end
        {dl, far_low} = 8'h00;
        wr(SMBTPC_TC_ADDR, 8'h00, 8'h00);
        for (s = 0; s < 4; s++)
        begin
            wr(SMBTPC_CF_ADDR, SMBTPC_CF_PAGE, 8'(8'h80 | s));
            for (i = 0; i < 4; i++)
            begin
                k = nt;
                ovf = 4'(1 << i);
                cyc(1);
                ovf = 4'h0;
                cyc(2);
                chk(8'(nt - k), 8'(i == s));
            end
        end
        wr(SMBTPC_CF_ADDR, SMBTPC_CF_PAGE, 8'h88);
        cyc(5);
        chk({6'h00, t4_reload_high, t4_reload_low}, 8'h03);
        t4_split = 1'b1;
        cyc(2);
        chk({6'h00, t4_reload_high, t4_reload_low}, 8'h02);
        far_low[3] = 1'b1;
        cyc(6);
        chk({6'h00, t4_reload_high, t4_reload_low}, 8'h00);
        {far_low[3], t4_split} = 2'b00;
        wr(SMBTPC_CF_ADDR, SMBTPC_CF_PAGE, 8'h80);
        for (s = 0; s < 4; s++)
        begin
            wr(SMBTPC_TC_ADDR, 8'h00, 8'(s << 2));
            if (s > 0) frame(1, wmin[s] - 1, 1'b0);
            frame(1, wmin[s] + 3, 1'b1);
        end
        wr(SMBTPC_TC_ADDR, 8'h00, 8'h03);
        frame(0, 7, 1'b0);
        frame(0, 11, 1'b1);
        frame(1, 1, 1'b1);
        // START, then data released under a low clock: busy, no STOP.
        wr(SMBTPC_CF_ADDR, SMBTPC_CF_PAGE, 8'h84);
        for (i = 0; i < 4; i++)
        begin
            far_low = 4'(16'h08C4 >> (4 * i)) & 4'hC;
            cyc(4);
        end
        cyc(4);
        k = nf;
        for (i = 1; i <= 11; i++)
        begin
            ovf[0] = 1'b1;
            cyc(1);
            ovf[0] = 1'b0;
            cyc(3);
            if (i == 10) chk(8'(nf - k) + {7'h00, c1_busy}, 8'h01);
        end
        chk({7'(nf - k), c1_busy}, 8'h02);
        final_report();
    end
endmodule // smbtpc_top_tb_top
